// File: bench/csd_delineator_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module csd_delineator_asserts #(parameter STRADDLE = 0) (
   // clock and configuration
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic cfg_addr_aligned,
   // stream
   input wire logic completion_valid,
   input wire logic completion_ready,
   input wire logic [511:0] completion_data_bus,
   input wire logic [15:0] completion_keep_bits,
   input wire logic completion_last_beat,
   // sideband
   input wire logic [63:0] completion_byte_valid,
   input wire logic [3:0] packet_start_flags,
   input wire logic [1:0] second_start_position,
   input wire logic [1:0] third_start_position,
   input wire logic [1:0] fourth_start_position,
   input wire logic [3:0] packet_end_flags,
   input wire logic completion_discontinue
);
   // *****
   // stream checks
   // *****
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   function automatic [63:0] spread(input [15:0] k);
      for (int i = 0; i < 16; i++) spread[4*i+:4] = {4{k[i]}};
   endfunction
   sequence s_stalled;
      completion_valid && !completion_ready;
   endsequence
   sequence s_held;
      completion_valid && $stable(completion_data_bus) && $stable(completion_byte_valid)
         && $stable(completion_keep_bits) && $stable(packet_start_flags);
   endsequence
   a_hold_stall: assert property (s_stalled |=> s_held)
      else $error("beat changed while stalled");
   a_start_code: assert property (completion_valid |-> packet_start_flags inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
      else $error("start flags not thermometer");
   a_end_code: assert property (completion_valid |-> packet_end_flags inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
      else $error("end flags not thermometer");
   a_aligned_single: assert property (cfg_addr_aligned && completion_valid |-> packet_start_flags[3:1] == 3'h0 && packet_end_flags[3:1] == 3'h0)
      else $error("aligned beat straddled");
   a_straddle_frame: assert property (STRADDLE != 0 && !cfg_addr_aligned && completion_valid |-> completion_keep_bits == 16'hFFFF && !completion_last_beat)
      else $error("straddle keep or last wrong");
   a_desc_beat_empty: assert property (cfg_addr_aligned && completion_valid && packet_start_flags[0] |-> completion_byte_valid == 64'h0)
      else $error("payload in aligned descriptor beat");
   a_aligned_keep: assert property (cfg_addr_aligned && completion_valid |-> completion_keep_bits[0] && (completion_keep_bits & (completion_keep_bits + 16'h0001)) == 16'h0)
      else $error("aligned keep has a gap");
   a_bytes_in_keep: assert property (completion_valid |-> (completion_byte_valid & ~spread(completion_keep_bits)) == 64'h0)
      else $error("byte valid outside kept dwords");
   a_start_slots: assert property (completion_valid |-> (!packet_start_flags[1] || second_start_position != 2'h0) && (!packet_start_flags[2] || third_start_position[1]) && (!packet_start_flags[3] || fourth_start_position == 2'h3))
      else $error("start position out of range");
   a_abort_ends: assert property (completion_valid && completion_discontinue |-> packet_end_flags[0])
      else $error("abort without packet end");
endmodule
bind csd_delineator csd_delineator_asserts #(.STRADDLE(STRADDLE)) chk_u (.*);
`default_nettype wire

// File: bench/csd_sink_model.sv
`timescale 1ns/10ps
`default_nettype none
module csd_sink_model (
   // clock and control
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic stall,
   // stream
   input wire logic completion_valid,
   input wire logic [511:0] completion_data_bus,
   input wire logic [63:0] completion_byte_valid,
   input wire logic [3:0] packet_start_flags,
   input wire logic completion_discontinue,
   output wire logic completion_ready
);
   // *****
   // consumer
   // *****
   logic [7:0] mem [0:63];
   logic [7:0] wptr, base, w, b;
   logic ph;
   // stall halves throughput: ready is high only on alternate cycles, so a beat waits at most one cycle
   assign completion_ready = !stall || ph;
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         wptr <= 8'h00;
         base <= 8'h00;
         ph <= 1'b0;
      end else begin
         ph <= ~ph;
         if (completion_valid && completion_ready) begin
            w = wptr;
            b = packet_start_flags[0] ? wptr : base;
            for (int i = 0; i < 64; i++) begin
               if (completion_byte_valid[i]) begin
                  mem[w[5:0]] = completion_data_bus[8*i+:8];
                  w = w + 8'h01;
               end
            end
            // bad packet: drop everything it wrote
            if (completion_discontinue) w = b;
            wptr <= w;
            base <= b;
         end
      end
   end
endmodule
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic sys_clk = 1'b0, sys_rst = 1'b1, cfg_addr_aligned = 1'b1, stall = 1'b0;
   logic src_valid = 1'b0, src_first = 1'b0, src_last = 1'b0, src_abort = 1'b0;
   logic [31:0] src_dword = 32'h0;
   logic [3:0] src_byte_valid = 4'h0;
   logic [1:0] src_addr_offset = 2'h0;
   logic src_ready, completion_valid, completion_ready, completion_last_beat;
   logic completion_discontinue;
   logic [511:0] completion_data_bus;
   logic [15:0] completion_keep_bits;
   logic [63:0] completion_byte_valid;
   logic [3:0] packet_start_flags, packet_end_flags, first_end_position, second_end_position;
   logic [3:0] third_end_position, fourth_end_position;
   logic [1:0] first_start_position, second_start_position, third_start_position;
   logic [1:0] fourth_start_position;
   int n_errors = 0, cmp_count = 0;
   logic [511:0] q_d[$];
   logic [63:0] q_bv[$];
   logic [15:0] q_k[$];
   logic [33:0] q_m[$];
   logic [63:0] r_bv [4] = '{64'h00000000000F0000, 64'h0000000000F00000,
      64'h000000000F000000, 64'h00000000F0000000};
   logic [15:0] r_keep [4] = '{16'h001F, 16'h003F, 16'h007F, 16'h00FF};
   csd_delineator #(.STRADDLE(1)) dut_u (.*);
   csd_sink_model sink_u (.*);
   initial forever #20 sys_clk = ~sys_clk;
   // *****
   // capture and helpers
   // *****
   always @(posedge sys_clk) begin
      if (!sys_rst && completion_valid === 1'b1 && completion_ready === 1'b1) begin
         q_d.push_back(completion_data_bus);
         q_bv.push_back(completion_byte_valid);
         q_k.push_back(completion_keep_bits);
         q_m.push_back({completion_last_beat, completion_discontinue, packet_start_flags,
            packet_end_flags, first_start_position, second_start_position,
            third_start_position, fourth_start_position, first_end_position,
            second_end_position, third_end_position, fourth_end_position});
      end
   end
   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic put(input logic [31:0] d, input logic [3:0] be, input logic f, l, a,
      input logic [1:0] off);
      src_valid <= 1'b1;
      src_dword <= d;
      src_byte_valid <= be;
      src_first <= f;
      src_last <= l;
      src_abort <= a;
      src_addr_offset <= off;
      @(posedge sys_clk);
      while (src_ready !== 1'b1) @(posedge sys_clk);
   endtask
   task automatic pkt(input int np, input logic [3:0] be, input logic ab,
      input logic [1:0] off, input logic [31:0] b);
      for (int i = 0; i < 3 + np; i++)
         put(b + i, (i < 3) ? 4'h0 : be, i == 0, i == 2 + np, ab && i == 2 + np, off);
   endtask
   task automatic drain(input int n);
      src_valid <= 1'b0;
      repeat (200) if (q_bv.size() < n) @(posedge sys_clk);
      repeat (4) @(posedge sys_clk);
   endtask
   task end_sim;
      if (n_errors == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge sys_clk);
      n_errors++;
      end_sim;
   end
   // *****
   // tests
   // *****
   initial begin
      repeat (6) @(posedge sys_clk);
      chk("rst_valid", 64'h0, completion_valid);
      chk("rst_ready", 64'h0, src_ready);
      sys_rst <= 1'b0;
      // aligned rows: offset k, one payload dword
      for (int k = 0; k < 4; k++) pkt(1, 4'hF, 1'b0, k[1:0], 32'hA0000000 + 32'h10 * k);
      drain(8);
      chk("beats", 64'd8, q_bv.size());
      for (int k = 0; k < 4; k++) begin
         chk("desc_bv", 64'h0, q_bv[2*k]);
         chk("start", 64'h1, q_m[2*k][31:28]);
         chk("desc_dw", 32'hA0000000 + 32'h10 * k, q_d[2*k][31:0]);
         chk("pay_bv", r_bv[k], q_bv[2*k+1]);
         chk("keep", r_keep[k], q_k[2*k+1]);
         chk("pay_dw", 32'hA0000003 + 32'h10 * k, q_d[2*k+1][32*(4+k)+:32]);
         chk("last", 64'h1, q_m[2*k+1][33]);
         chk("eptr_al", 64'h4 + k, q_m[2*k+1][15:12]);
      end
      // straddle: four starts, then zero-length read and an aborted packet
      sys_rst <= 1'b1;
      cfg_addr_aligned <= 1'b0;
      stall <= 1'b1;
      q_d.delete();
      q_bv.delete();
      q_k.delete();
      q_m.delete();
      repeat (6) @(posedge sys_clk);
      chk("rst_valid2", 64'h0, completion_valid);
      chk("rst_ready2", 64'h0, src_ready);
      sys_rst <= 1'b0;
      for (int p = 0; p < 4; p++) pkt(0, 4'h0, 1'b0, 2'h0, 32'hB0000000 + 32'h10 * p);
      pkt(1, 4'h0, 1'b0, 2'h0, 32'hC0000000);
      pkt(1, 4'hF, 1'b1, 2'h0, 32'hD0000000);
      drain(2);
      chk("beats", 64'd2, q_bv.size());
      chk("flags0", 18'h0FF1B, q_m[0][33:16]);
      chk("eptr0", 16'h26AE, q_m[0][15:0]);
      chk("keep0", 16'hFFFF, q_k[0]);
      chk("bv0", 64'h0, q_bv[0]);
      for (int p = 0; p < 4; p++)
         for (int i = 0; i < 3; i++)
            chk("dw", 32'hB0000000 + 32'h10 * p + i, q_d[0][32*(4*p+i)+:32]);
      chk("flags1", 14'h1331, q_m[1][33:20]);
      chk("eptr1", 8'h37, q_m[1][15:8]);
      chk("bv1", 64'h00000000F0000000, q_bv[1]);
      chk("dummy", 32'hC0000003, q_d[1][127:96]);
      chk("wptr", 64'h0, sink_u.wptr);
      end_sim;
   end
endmodule
`default_nettype wire

// File: common/csd_defs.vh
`ifndef CSD_DEFS_VH
`define CSD_DEFS_VH

// ****************************************************
// beat geometry
// ****************************************************
`define CSD_DWORD_W 32
`define CSD_BEAT_DWORDS 16
`define CSD_BEAT_BYTES 64
`define CSD_DATA_W 512
`define CSD_PTR_W 5
`define CSD_POS_W 4

// ****************************************************
// packet layout
// ****************************************************
// descriptor length in dwords
`define CSD_DESC_DWORDS 3
// index of the last descriptor dword
`define CSD_DESC_LAST_IDX 2'h2
// saturated index meaning "in the payload"
`define CSD_PAYLOAD_IDX 2'h3
// aligned payload base: dword 4 is byte lane 16
`define CSD_ALIGN_BASE 4'h4
// straddle slots sit on multiples of this many dwords
`define CSD_SLOT_DWORDS 4
`define CSD_MAX_STARTS 3'h4

// ****************************************************
// reset and fixed values
// ****************************************************
`define CSD_KEEP_ALL 16'hFFFF
`define CSD_KEEP_NONE 16'h0000
`define CSD_BEAT_END 5'h10

`endif

// File: core/csd_delineator.v
// Overview of operation
// - start flag bit zero rises in the beat carrying a packet's descriptor
// - sixty-four byte-valid bits mark payload bytes only, never descriptor or filler
// - byte-valid runs are contiguous except payloads of two dwords or less
// - zero-length read answer carries one payload dword with all byte-valid bits clear
// - address-aligned payload starts in the beat after the descriptor ends
// - address-aligned first payload byte lands on lanes 16 through 31
// - address-aligned keep bits run unbroken from dword 0 through the last descriptor or payload dword of the beat
// - in address-aligned mode, request alignment offset places the first payload dword in its 128-bit field
// - straddle build option allows up to four packet starts per beat
// - straddling only in dword-aligned placement; address-aligned is never straddled
// - while straddling, keep is all ones and last-beat stays low
// - without straddle only start flag bit zero may be set
// - straddled start flags are thermometer coded 0000 to 1111
// - first start position gives dword 0, 4, 8 or 12
// - second start position is 01, 10 or 11
// - third start position is 10 or 11
// - fourth start position is always 11
// - dword-aligned: three descriptor dwords then payload, one stream packet
// - valid stays high across a beat; ready low stretches the beat
// - end flags thermometer coded with a last-dword pointer per ending packet
// - abort flag in the last beat of a bad packet, no new start there
`timescale 1ns/10ps
`default_nettype none
`include "csd_defs.vh"

module csd_delineator #(
   parameter STRADDLE = 0
) (
   // clock and reset
   input wire sys_clk,
   input wire sys_rst,
   // configuration
   input wire cfg_addr_aligned,
   // completion dwords from the core, one per cycle
   input wire src_valid,
   output reg src_ready,
   input wire [`CSD_DWORD_W-1:0] src_dword,
   input wire [3:0] src_byte_valid,
   input wire src_first,
   input wire src_last,
   input wire src_abort,
   input wire [1:0] src_addr_offset,
   // stream master
   output reg completion_valid,
   input wire completion_ready,
   output reg [`CSD_DATA_W-1:0] completion_data_bus,
   output reg [`CSD_BEAT_DWORDS-1:0] completion_keep_bits,
   output reg completion_last_beat,
   // sideband
   output reg [`CSD_BEAT_BYTES-1:0] completion_byte_valid,
   output reg [3:0] packet_start_flags,
   output reg [1:0] first_start_position,
   output reg [1:0] second_start_position,
   output reg [1:0] third_start_position,
   output reg [1:0] fourth_start_position,
   output reg [3:0] packet_end_flags,
   output reg [3:0] first_end_position,
   output reg [3:0] second_end_position,
   output reg [3:0] third_end_position,
   output reg [3:0] fourth_end_position,
   output reg completion_discontinue
);

   // ****************************************************
   // helpers
   // ****************************************************
   function [3:0] thermo;
      input [2:0] n;
      begin
         case (n)
            3'h0: thermo = 4'h0;
            3'h1: thermo = 4'h1;
            3'h2: thermo = 4'h3;
            3'h3: thermo = 4'h7;
            default: thermo = 4'hF;
         endcase
      end
   endfunction

   // ones from dword 0 up to and including dword p
   function [`CSD_BEAT_DWORDS-1:0] keep_upto;
      input [`CSD_POS_W-1:0] p;
      integer k;
      begin
         keep_upto = `CSD_KEEP_NONE;
         for (k = 0; k < `CSD_BEAT_DWORDS; k = k + 1) begin
            if (k <= p) begin
               keep_upto[k] = 1'b1;
            end
         end
      end
   endfunction

   // next free straddle slot at or above p
   function [`CSD_PTR_W-1:0] slot_up;
      input [`CSD_PTR_W-1:0] p;
      begin
         slot_up = {p[4:2] + {2'h0, |p[1:0]}, 2'h0};
      end
   endfunction

   // ****************************************************
   // assembly beat state
   // ****************************************************
   reg [`CSD_DATA_W-1:0] asm_data;
   reg [`CSD_BEAT_DWORDS-1:0] asm_keep;
   reg [`CSD_BEAT_BYTES-1:0] asm_bv;
   reg [2:0] asm_starts;
   reg [7:0] asm_start_pos;
   reg [2:0] asm_ends;
   reg [15:0] asm_end_pos;
   reg asm_abort;
   reg [`CSD_PTR_W-1:0] asm_ptr;
   reg asm_done;
   reg [1:0] pkt_idx;
   reg [1:0] pkt_offset;
   // marks the first payload dword of an address-aligned packet
   reg pay_first;
   reg next_pay_first;

   reg [`CSD_DATA_W-1:0] next_data;
   reg [`CSD_BEAT_DWORDS-1:0] next_keep;
   reg [`CSD_BEAT_BYTES-1:0] next_bv;
   reg [2:0] next_starts;
   reg [7:0] next_start_pos;
   reg [2:0] next_ends;
   reg [15:0] next_end_pos;
   reg next_abort;
   reg [`CSD_PTR_W-1:0] next_ptr;
   reg next_done;
   reg [1:0] next_idx;
   reg [1:0] next_offset;
   reg [`CSD_POS_W-1:0] pos;
   reg [1:0] cur_offset;

   // config assumed static while traffic flows
   wire straddle_on = (STRADDLE != 0) && !cfg_addr_aligned;
   wire take = src_valid & src_ready;
   wire move = asm_done & (~completion_valid | completion_ready);

   // ****************************************************
   // beat assembly
   // ****************************************************
   // limitation: in straddle mode a beat left open after a packet end
   // closes only when more dwords arrive or position 16 is reached
   always @* begin
      next_data = asm_data;
      next_keep = asm_keep;
      next_bv = asm_bv;
      next_starts = asm_starts;
      next_start_pos = asm_start_pos;
      next_ends = asm_ends;
      next_end_pos = asm_end_pos;
      next_abort = asm_abort;
      next_ptr = asm_ptr;
      next_done = asm_done;
      next_idx = pkt_idx;
      next_offset = pkt_offset;
      next_pay_first = pay_first;
      cur_offset = src_first ? src_addr_offset : pkt_offset;
      pos = asm_ptr[`CSD_POS_W-1:0];
      if (move) begin
         next_data = {`CSD_DATA_W{1'b0}};
         next_keep = `CSD_KEEP_NONE;
         next_bv = {`CSD_BEAT_BYTES{1'b0}};
         next_starts = 3'h0;
         next_start_pos = 8'h00;
         next_ends = 3'h0;
         next_end_pos = 16'h0000;
         next_abort = 1'b0;
         next_ptr = 5'h00;
         next_done = 1'b0;
      end
      if (take) begin
         // only the first payload dword is offset; later payload beats start at dword 0
         next_pay_first = cfg_addr_aligned && (pkt_idx == `CSD_DESC_LAST_IDX)
            && !src_first && !src_last;
         // first payload dword in aligned mode opens a fresh beat
         if (cfg_addr_aligned && pay_first) begin
            pos = `CSD_ALIGN_BASE + {2'h0, cur_offset};
         end
         next_data[pos*`CSD_DWORD_W +: `CSD_DWORD_W] = src_dword;
         // filler dwords below pos stay kept but carry no valid bytes
         next_keep = asm_keep | keep_upto(pos);
         if (pkt_idx == `CSD_PAYLOAD_IDX && !src_first) begin
            // payload lanes copy the source enables as delivered
            next_bv[pos*4 +: 4] = src_byte_valid;
         end
         if (src_first) begin
            next_offset = src_addr_offset;
            next_start_pos[asm_starts[1:0]*2 +: 2] = pos[3:2];
            next_starts = asm_starts + 3'h1;
         end
         next_ptr = {1'b0, pos} + 5'h01;
         if (src_last) begin
            next_end_pos[asm_ends[1:0]*4 +: 4] = pos;
            next_ends = asm_ends + 3'h1;
            next_abort = asm_abort | src_abort;
            next_idx = 2'h0;
            if (!straddle_on || src_abort) begin
               next_done = 1'b1;
            end else begin
               next_ptr = slot_up({1'b0, pos} + 5'h01);
               if (next_ptr == `CSD_BEAT_END) begin
                  next_done = 1'b1;
               end
            end
         end else begin
            if (src_first) begin
               next_idx = 2'h1;
            end else if (pkt_idx != `CSD_PAYLOAD_IDX) begin
               next_idx = pkt_idx + 2'h1;
            end
            if (cfg_addr_aligned && pkt_idx == `CSD_DESC_LAST_IDX) begin
               next_done = 1'b1;
            end else if (next_ptr == `CSD_BEAT_END) begin
               next_done = 1'b1;
            end
         end
      end
   end

   // ****************************************************
   // assembly registers
   // ****************************************************
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         pay_first <= 1'b0;
         asm_data <= {`CSD_DATA_W{1'b0}};
         asm_keep <= `CSD_KEEP_NONE;
         asm_bv <= {`CSD_BEAT_BYTES{1'b0}};
         asm_starts <= 3'h0;
         asm_start_pos <= 8'h00;
         asm_ends <= 3'h0;
         asm_end_pos <= 16'h0000;
         asm_abort <= 1'b0;
         asm_ptr <= 5'h00;
         asm_done <= 1'b0;
         pkt_idx <= 2'h0;
         pkt_offset <= 2'h0;
         src_ready <= 1'b0;
      end else begin
         pay_first <= next_pay_first;
         asm_data <= next_data;
         asm_keep <= next_keep;
         asm_bv <= next_bv;
         asm_starts <= next_starts;
         asm_start_pos <= next_start_pos;
         asm_ends <= next_ends;
         asm_end_pos <= next_end_pos;
         asm_abort <= next_abort;
         asm_ptr <= next_ptr;
         asm_done <= next_done;
         pkt_idx <= next_idx;
         pkt_offset <= next_offset;
         // registered ready: a closed beat blocks intake until it moves out
         src_ready <= ~next_done;
      end
   end

   // ****************************************************
   // output beat register
   // ****************************************************
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         completion_valid <= 1'b0;
         completion_data_bus <= {`CSD_DATA_W{1'b0}};
         completion_keep_bits <= `CSD_KEEP_NONE;
         completion_last_beat <= 1'b0;
         completion_byte_valid <= {`CSD_BEAT_BYTES{1'b0}};
         packet_start_flags <= 4'h0;
         first_start_position <= 2'h0;
         second_start_position <= 2'h0;
         third_start_position <= 2'h0;
         fourth_start_position <= 2'h0;
         packet_end_flags <= 4'h0;
         first_end_position <= 4'h0;
         second_end_position <= 4'h0;
         third_end_position <= 4'h0;
         fourth_end_position <= 4'h0;
         completion_discontinue <= 1'b0;
      end else if (move) begin
         // only loads once the previous beat is taken
         completion_valid <= 1'b1;
         completion_data_bus <= asm_data;
         completion_keep_bits <= straddle_on ? `CSD_KEEP_ALL : asm_keep;
         completion_last_beat <= !straddle_on && (asm_ends != 3'h0);
         completion_byte_valid <= asm_bv;
         packet_start_flags <= thermo(asm_starts);
         first_start_position <= asm_start_pos[1:0];
         second_start_position <= asm_start_pos[3:2];
         third_start_position <= asm_start_pos[5:4];
         fourth_start_position <= asm_start_pos[7:6];
         packet_end_flags <= thermo(asm_ends);
         first_end_position <= asm_end_pos[3:0];
         second_end_position <= asm_end_pos[7:4];
         third_end_position <= asm_end_pos[11:8];
         fourth_end_position <= asm_end_pos[15:12];
         completion_discontinue <= asm_abort;
      end else if (completion_ready) begin
         completion_valid <= 1'b0;
      end
   end

endmodule
`default_nettype wire
